// ### logic/sar_adc_pkg.sv
`default_nettype none
package sar_adc_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Widths and counts
  localparam int unsigned RESULT_W = 10;
  localparam int unsigned CHAN_W = 4;
  localparam int unsigned PIN_W = 12;
  localparam int unsigned CONV_TADS = 11;
  localparam logic [3:0] CONV_INIT_IDX = 4'(CONV_TADS - 1);
  localparam logic [4:0] HOLDOFF_TADS = 5'h02;

  ////////////////////////////////////////////////////////////////////////////
  // Register offsets (byte addresses)
  localparam logic [7:0] OFF_CTRL0 = 8'h00;
  localparam logic [7:0] OFF_CTRL1 = 8'h04;
  localparam logic [7:0] OFF_CTRL2 = 8'h08;
  localparam logic [7:0] OFF_RESL = 8'h0C;
  localparam logic [7:0] OFF_RESH = 8'h10;
  localparam logic [7:0] OFF_IRQ = 8'h14;
  localparam logic [7:0] OFF_ANSEL = 8'h18;
  localparam logic [7:0] OFF_DIR = 8'h1C;
  localparam logic [7:0] OFF_PORT_OUT = 8'h20;
  localparam logic [7:0] OFF_PORT_IN = 8'h24;

  ////////////////////////////////////////////////////////////////////////////
  // Field positions
  localparam int unsigned EN_BIT = 0;
  localparam int unsigned GO_BIT = 1;
  localparam int unsigned CHS_LSB = 2;
  localparam int unsigned PREF_LSB = 0;
  localparam int unsigned NREF_BIT = 2;
  localparam int unsigned CS_LSB = 0;
  localparam int unsigned ACQ_LSB = 3;
  localparam int unsigned FLAG_BIT = 0;
  localparam int unsigned IRQ_EN_BIT = 1;

  ////////////////////////////////////////////////////////////////////////////
  // Encodings and reset values
  localparam logic [2:0] ACQ_MANUAL = 3'h0;
  localparam logic [2:0] ACQ_RESET = ACQ_MANUAL;
  localparam logic [2:0] CS_RESET = 3'h0;
  localparam logic [1:0] CS_RC = 2'h3;
  localparam logic [1:0] PREF_SUPPLY = 2'h0;
  localparam logic [1:0] PREF_FIXED = 2'h1;
  localparam logic [1:0] PREF_PIN = 2'h2;
  localparam logic NREF_GND = 1'b0;
  localparam logic NREF_PIN = 1'b1;
  localparam logic [PIN_W-1:0] ANSEL_RESET = 12'hFFF;
  localparam logic [PIN_W-1:0] DIR_RESET = 12'hFFF;
  localparam logic [RESULT_W-1:0] CODE_MSB = 10'h200;

  typedef enum logic [1:0] {
    SEQ_IDLE = 2'h0,
    SEQ_ACQ = 2'h1,
    SEQ_CONV = 2'h3,
    SEQ_HOLD = 2'h2
  } seq_state_t;

  // Drive toward the analog mux and capacitor array
  typedef struct packed {
    logic sample;
    logic discharge;
    logic [CHAN_W-1:0] channel_select;
    logic [1:0] pos_ref_select;
    logic neg_ref_select;
    logic [RESULT_W-1:0] dac_code;
  } afe_t;

  typedef struct packed {
    logic [5:0] cnt;
    logic rc_prev;
    logic tick;
  } div_t;

  typedef struct packed {
    seq_state_t st;
    logic [3:0] bit_idx;
    logic [4:0] cnt;
    logic [RESULT_W-1:0] code;
    logic last_bit;
    logic conv_enable;
    logic go;
    logic [CHAN_W-1:0] channel;
    logic [1:0] pos_ref;
    logic neg_ref;
    logic [2:0] clk_sel;
    logic [2:0] acq_sel;
    logic [RESULT_W-1:0] result;
    logic flag;
    logic irq_en;
    logic irq;
    logic sample;
    logic discharge;
    logic [PIN_W-1:0] ana_sel;
    logic [PIN_W-1:0] dir;
    logic [PIN_W-1:0] port_out;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } core_t;

  // Acquisition length in bit periods per acq_time_select code
  function automatic logic [4:0] acq_tads(input logic [2:0] code);
    case (code)
      3'h1: acq_tads = 5'h02;
      3'h2: acq_tads = 5'h04;
      3'h3: acq_tads = 5'h06;
      3'h4: acq_tads = 5'h08;
      3'h5: acq_tads = 5'h0C;
      3'h6: acq_tads = 5'h10;
      3'h7: acq_tads = 5'h14;
      default: acq_tads = 5'h00;
    endcase
  endfunction : acq_tads

endpackage : sar_adc_pkg
`default_nettype wire

// ### logic/sync2.sv
`default_nettype none
module sync2 #(
  parameter int unsigned W = 1
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Asynchronous in, synchronised out
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);

  logic [2*W-1:0] s_r;
  logic [2*W-1:0] s_nxt;

  // First stage feeds only the second stage
  always_comb begin
    s_nxt = {s_r[W-1:0], d};
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign q = s_r[2*W-1:W];

endmodule : sync2
`default_nettype wire

// ### logic/tad_divider.sv
`default_nettype none
module tad_divider (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Control
  input wire logic run,
  input wire logic [2:0] sel,
  input wire logic rc_lvl,
  // One pulse per bit period
  output logic tad_tick
);

  sar_adc_pkg::div_t s_r;
  sar_adc_pkg::div_t s_nxt;
  logic [2:0] idx;
  logic [5:0] lim;

  always_comb begin
    s_nxt = s_r;
    // Codes 000,100,001,101,010,110 divide by 2,4,8,16,32,64
    idx = {sel[1:0], sel[2]};
    lim = 6'((7'h02 << idx) - 7'h01);
    s_nxt.rc_prev = rc_lvl;
    s_nxt.tick = 1'b0;
    if (!run) begin
      // Restart so the first period after a start is a full one
      s_nxt.cnt = 6'h00;
    end else if (sel[1:0] == sar_adc_pkg::CS_RC) begin
      s_nxt.tick = rc_lvl & ~s_r.rc_prev;
    end else if (s_r.cnt == lim) begin
      s_nxt.cnt = 6'h00;
      s_nxt.tick = 1'b1;
    end else begin
      s_nxt.cnt = s_r.cnt + 6'h01;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign tad_tick = s_r.tick;

endmodule : tad_divider
`default_nettype wire

// ### logic/sar_adc_sequencer.sv
`default_nettype none
// How it works
// - Successive approximation gives a 10-bit value kept in result registers.
// - Completion sets a flag that, when enabled, raises the wake interrupt.
// - Channel select picks the input routed to the sample-and-hold.
// - Positive reference: supply, fixed or pin; negative: ground or pin.
// - Nonzero acquisition code samples 2 to 20 bit periods, then converts.
// - Acquisition code 000 converts at once and is the reset value.
// - End of conversion clears go, sets the flag, starts the discharge hold-off.
// - Go stays set through acquisition; no phase status is shown.
// - Seven conversion clocks: system clock over 2 to 64, or RC.
// - A full conversion lasts eleven bit periods.
// - Port reads return low on every pin marked analog.
// - Conversion ignores analog-select and direction bits.
// - Non-RC conversion clocks are divided from the system clock.
// - Acquisition code 010 gives four bit periods.
// - Clearing go early loads a partial result, padded by last bit.
// - Two bit periods pass before sampling resumes after end or abort.
module sar_adc_sequencer (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Comparator and conversion oscillator
  input wire logic comp_in,
  input wire logic rc_osc,
  // Analog front end control
  output sar_adc_pkg::afe_t afe_ctl,
  // Port pins
  input wire logic [sar_adc_pkg::PIN_W-1:0] pin_in,
  output logic [sar_adc_pkg::PIN_W-1:0] pin_out,
  output logic [sar_adc_pkg::PIN_W-1:0] pin_oe_n,
  // Completion interrupt, also the wake request
  output logic conv_irq
);

  ////////////////////////////////////////////////////////////////////////////
  // Declarations

  localparam int unsigned PW = sar_adc_pkg::PIN_W;
  localparam int unsigned RW = sar_adc_pkg::RESULT_W;

  sar_adc_pkg::core_t s_r;
  sar_adc_pkg::core_t s_nxt;

  logic comp_s;
  logic rc_s;
  logic [PW-1:0] pin_s;
  logic tad_tick;
  logic seq_run;

  logic setup;
  logic wr;
  logic hit;
  logic [31:0] rd;
  logic go_set;
  logic go_clr;
  logic abort;
  logic done;
  logic dec;

  // Unresolved bits copy the last resolved bit
  function automatic logic [RW-1:0] partial_result(
    input logic [RW-1:0] code,
    input logic [3:0] idx,
    input logic last
  );
    logic [RW-1:0] r;
    r = '0;
    for (int i = 0; i < RW; i++) begin
      r[i] = (4'(i) > idx) ? code[i] : last;
    end
    return r;
  endfunction : partial_result

  ////////////////////////////////////////////////////////////////////////////
  // Synchronisers and bit-period divider

  sync2 #(
    .W(PW + 2)
  ) u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .d({comp_in, rc_osc, pin_in}),
    .q({comp_s, rc_s, pin_s})
  );

  // An abort lands between ticks; restarting the divider there gives the
  // hold-off two full bit periods instead of a short first one
  assign seq_run = (s_r.st != sar_adc_pkg::SEQ_IDLE) && !abort;

  tad_divider u_div (
    .pclk(pclk),
    .presetn(presetn),
    .run(seq_run),
    .sel(s_r.clk_sel),
    .rc_lvl(rc_s),
    .tad_tick(tad_tick)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Next state

  always_comb begin
    s_nxt = s_r;
    rd = 32'h0000_0000;
    hit = 1'b1;
    go_set = 1'b0;
    go_clr = 1'b0;
    abort = 1'b0;
    done = 1'b0;
    dec = 1'b0;
    setup = psel & ~penable;
    wr = psel & penable & pwrite & s_r.pready;

    // Read mux, sampled in the setup cycle
    case (paddr)
      sar_adc_pkg::OFF_CTRL0: begin
        rd[sar_adc_pkg::EN_BIT] = s_r.conv_enable;
        rd[sar_adc_pkg::GO_BIT] = s_r.go;
        rd[sar_adc_pkg::CHS_LSB +: sar_adc_pkg::CHAN_W] = s_r.channel;
      end
      sar_adc_pkg::OFF_CTRL1: begin
        rd[sar_adc_pkg::PREF_LSB +: 2] = s_r.pos_ref;
        rd[sar_adc_pkg::NREF_BIT] = s_r.neg_ref;
      end
      sar_adc_pkg::OFF_CTRL2: begin
        rd[sar_adc_pkg::CS_LSB +: 3] = s_r.clk_sel;
        rd[sar_adc_pkg::ACQ_LSB +: 3] = s_r.acq_sel;
      end
      sar_adc_pkg::OFF_RESL: begin
        rd[7:0] = s_r.result[7:0];
      end
      sar_adc_pkg::OFF_RESH: begin
        rd[RW-9:0] = s_r.result[RW-1:8];
      end
      sar_adc_pkg::OFF_IRQ: begin
        rd[sar_adc_pkg::FLAG_BIT] = s_r.flag;
        rd[sar_adc_pkg::IRQ_EN_BIT] = s_r.irq_en;
      end
      sar_adc_pkg::OFF_ANSEL: begin
        rd[PW-1:0] = s_r.ana_sel;
      end
      sar_adc_pkg::OFF_DIR: begin
        rd[PW-1:0] = s_r.dir;
      end
      sar_adc_pkg::OFF_PORT_OUT: begin
        rd[PW-1:0] = s_r.port_out;
      end
      sar_adc_pkg::OFF_PORT_IN: begin
        rd[PW-1:0] = pin_s & ~s_r.ana_sel;
      end
      default: begin
        hit = 1'b0;
      end
    endcase

    // One wait-free access phase; answer flops load during setup
    s_nxt.pready = setup;
    s_nxt.pslverr = setup & ~hit;
    if (setup) begin
      s_nxt.prdata = rd;
    end

    // Register writes land on the access edge
    if (wr) begin
      case (paddr)
        sar_adc_pkg::OFF_CTRL0: begin
          s_nxt.conv_enable = pwdata[sar_adc_pkg::EN_BIT];
          s_nxt.channel = pwdata[sar_adc_pkg::CHS_LSB +: sar_adc_pkg::CHAN_W];
          go_set = pwdata[sar_adc_pkg::GO_BIT];
          go_clr = ~pwdata[sar_adc_pkg::GO_BIT];
        end
        sar_adc_pkg::OFF_CTRL1: begin
          s_nxt.pos_ref = pwdata[sar_adc_pkg::PREF_LSB +: 2];
          s_nxt.neg_ref = pwdata[sar_adc_pkg::NREF_BIT];
        end
        sar_adc_pkg::OFF_CTRL2: begin
          s_nxt.clk_sel = pwdata[sar_adc_pkg::CS_LSB +: 3];
          s_nxt.acq_sel = pwdata[sar_adc_pkg::ACQ_LSB +: 3];
        end
        sar_adc_pkg::OFF_IRQ: begin
          s_nxt.irq_en = pwdata[sar_adc_pkg::IRQ_EN_BIT];
          // Write one to clear; a completion in the same cycle wins below
          if (pwdata[sar_adc_pkg::FLAG_BIT]) begin
            s_nxt.flag = 1'b0;
          end
        end
        sar_adc_pkg::OFF_ANSEL: begin
          s_nxt.ana_sel = pwdata[PW-1:0];
        end
        sar_adc_pkg::OFF_DIR: begin
          s_nxt.dir = pwdata[PW-1:0];
        end
        sar_adc_pkg::OFF_PORT_OUT: begin
          s_nxt.port_out = pwdata[PW-1:0];
        end
        default: begin
        end
      endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // Conversion sequencer; runs whatever the pin configuration is
    case (s_r.st)
      sar_adc_pkg::SEQ_IDLE: begin
        // A go written while busy or in hold-off is dropped
        if (go_set && s_nxt.conv_enable) begin
          s_nxt.go = 1'b1;
          s_nxt.code = '0;
          s_nxt.last_bit = 1'b0;
          s_nxt.bit_idx = sar_adc_pkg::CONV_INIT_IDX;
          s_nxt.cnt = sar_adc_pkg::acq_tads(s_r.acq_sel);
          if (s_r.acq_sel == sar_adc_pkg::ACQ_MANUAL) begin
            s_nxt.st = sar_adc_pkg::SEQ_CONV;
          end else begin
            s_nxt.st = sar_adc_pkg::SEQ_ACQ;
          end
        end
      end
      sar_adc_pkg::SEQ_ACQ: begin
        if (go_clr || !s_nxt.conv_enable) begin
          abort = 1'b1;
        end else if (tad_tick) begin
          if (s_r.cnt == 5'h01) begin
            s_nxt.st = sar_adc_pkg::SEQ_CONV;
          end else begin
            s_nxt.cnt = s_r.cnt - 5'h01;
          end
        end
      end
      sar_adc_pkg::SEQ_CONV: begin
        if (go_clr || !s_nxt.conv_enable) begin
          abort = 1'b1;
        end else if (tad_tick) begin
          if (s_r.bit_idx == sar_adc_pkg::CONV_INIT_IDX) begin
            // Initial period, then try the MSB
            s_nxt.code = sar_adc_pkg::CODE_MSB;
            s_nxt.bit_idx = 4'(RW - 1);
          end else begin
            dec = comp_s;
            s_nxt.code[s_r.bit_idx] = dec;
            s_nxt.last_bit = dec;
            if (s_r.bit_idx == 4'h0) begin
              done = 1'b1;
            end else begin
              s_nxt.code[s_r.bit_idx - 4'h1] = 1'b1;
              s_nxt.bit_idx = s_r.bit_idx - 4'h1;
            end
          end
        end
      end
      sar_adc_pkg::SEQ_HOLD: begin
        if (tad_tick) begin
          if (s_r.cnt == 5'h01) begin
            s_nxt.st = sar_adc_pkg::SEQ_IDLE;
          end else begin
            s_nxt.cnt = s_r.cnt - 5'h01;
          end
        end
      end
      default: begin
        s_nxt.st = sar_adc_pkg::SEQ_IDLE;
      end
    endcase

    if (done) begin
      s_nxt.result = s_nxt.code;
      s_nxt.flag = 1'b1;
    end else if (abort) begin
      s_nxt.result = partial_result(s_r.code, s_r.bit_idx,
                                    s_r.last_bit);
    end
    if (done || abort) begin
      s_nxt.go = 1'b0;
      s_nxt.st = sar_adc_pkg::SEQ_HOLD;
      s_nxt.cnt = sar_adc_pkg::HOLDOFF_TADS;
    end

    // Sampling resumes only once hold-off ends
    s_nxt.sample = s_nxt.conv_enable &&
                   (s_nxt.st == sar_adc_pkg::SEQ_IDLE ||
                    s_nxt.st == sar_adc_pkg::SEQ_ACQ);
    s_nxt.discharge = (s_nxt.st == sar_adc_pkg::SEQ_HOLD);
    // Level output; serves as the wake request while asleep
    s_nxt.irq = s_nxt.flag & s_nxt.irq_en;
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_r <= '0;
      s_r.st <= sar_adc_pkg::SEQ_IDLE;
      s_r.acq_sel <= sar_adc_pkg::ACQ_RESET;
      s_r.clk_sel <= sar_adc_pkg::CS_RESET;
      s_r.pos_ref <= sar_adc_pkg::PREF_SUPPLY;
      s_r.neg_ref <= sar_adc_pkg::NREF_GND;
      s_r.ana_sel <= sar_adc_pkg::ANSEL_RESET;
      s_r.dir <= sar_adc_pkg::DIR_RESET;
    end else begin
      s_r <= s_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs, all from the state register

  assign prdata = s_r.prdata;
  assign pready = s_r.pready;
  assign pslverr = s_r.pslverr;
  assign conv_irq = s_r.irq;
  assign pin_out = s_r.port_out;
  // Direction bit set means input, so the driver is off
  assign pin_oe_n = s_r.dir;
  // Whole bundle in one assignment, so it has a single driver
  assign afe_ctl = '{
    sample: s_r.sample,
    discharge: s_r.discharge,
    channel_select: s_r.channel,
    pos_ref_select: s_r.pos_ref,
    neg_ref_select: s_r.neg_ref,
    dac_code: s_r.code
  };

endmodule : sar_adc_sequencer
`default_nettype wire

// ### tb/sar_adc_sequencer_assertions.sv
`default_nettype none
module sar_adc_checker (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Analog side, pins, interrupt
  input wire logic comp_in,
  input wire logic rc_osc,
  input wire sar_adc_pkg::afe_t afe_ctl,
  input wire logic [sar_adc_pkg::PIN_W-1:0] pin_in,
  input wire logic [sar_adc_pkg::PIN_W-1:0] pin_out,
  input wire logic [sar_adc_pkg::PIN_W-1:0] pin_oe_n,
  input wire logic conv_irq
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [sar_adc_pkg::PIN_W-1:0] ansel_r;
  // Shadow of the analog-select mask, so port reads can be judged
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ansel_r <= sar_adc_pkg::ANSEL_RESET;
    end else if (psel && penable && pready && pwrite
                 && paddr == sar_adc_pkg::OFF_ANSEL) begin
      ansel_r <= pwdata[sar_adc_pkg::PIN_W-1:0];
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_write(logic [7:0] a);
    psel && penable && pready && pwrite && paddr == a;
  endsequence
  a_ready_after_setup: assert property (psel && !penable |=> pready)
    else $error("pready missing after setup");
  a_error_with_ready: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  a_refs_follow: assert property (
    s_write(sar_adc_pkg::OFF_CTRL1) |=> afe_ctl.pos_ref_select ==
    $past(pwdata[1:0]) && afe_ctl.neg_ref_select == $past(pwdata[2]))
    else $error("reference select not applied");
  a_channel_follows: assert property (
    s_write(sar_adc_pkg::OFF_CTRL0) |=>
    afe_ctl.channel_select == $past(pwdata[5:2]))
    else $error("channel select not applied");
  a_port_analog_low: assert property (
    psel && penable && !pwrite && paddr == sar_adc_pkg::OFF_PORT_IN |->
    (prdata[sar_adc_pkg::PIN_W-1:0] & ansel_r) == 0)
    else $error("analog pin read high");
  a_hold_no_sample: assert property (
    afe_ctl.discharge |-> !afe_ctl.sample)
    else $error("sampling during hold-off");
  a_resume_after_hold: assert property (
    $fell(afe_ctl.discharge) |-> afe_ctl.sample)
    else $error("sampling not resumed after hold-off");
  a_conv_min_len: assert property (
    $fell(afe_ctl.sample) |-> !afe_ctl.discharge [*8])
    else $error("conversion ended too soon");
  a_conv_bounded: assert property (
    $fell(afe_ctl.sample) |-> ##[1:1000] afe_ctl.discharge)
    else $error("conversion never ended");
  a_first_trial_msb: assert property (
    $changed(afe_ctl.dac_code) && $past(afe_ctl.dac_code) == 0 &&
    !afe_ctl.sample && !afe_ctl.discharge |->
    afe_ctl.dac_code == sar_adc_pkg::CODE_MSB)
    else $error("first trial code is not the top bit");
endmodule : sar_adc_checker
`default_nettype wire

// ### tb/sar_afe_model.sv
`default_nettype none
module sar_afe_model (
  // Clock
  input wire logic pclk,
  // Control from the sequencer
  input wire sar_adc_pkg::afe_t afe_ctl,
  // Level present on each channel
  input wire logic [15:0][9:0] levels,
  // Comparator decision
  output logic comp_in
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [9:0] held_r = 10'h000;
  // The cap follows the routed channel only while connected
  always @(posedge pclk) begin
    if (afe_ctl.sample) begin
      held_r <= levels[afe_ctl.channel_select];
    end
  end
  // A discharged array gives no usable decision, so it toggles
  assign comp_in = afe_ctl.discharge ? pclk
                   : (held_r >= afe_ctl.dac_code);
endmodule : sar_afe_model
`default_nettype wire

// ### tb/sar_adc_sequencer_test.sv
`default_nettype none
module sar_adc_sequencer_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic comp_in;
  logic rc_osc = 1'b0;
  sar_adc_pkg::afe_t afe_ctl;
  logic [11:0] pin_in = 12'h000;
  logic [11:0] pin_out;
  logic [11:0] pin_oe_n;
  logic conv_irq;
  logic [15:0][9:0] levels;
  logic [31:0] rd;
  logic err;
  logic irq_on = 1'b0;
  int bad_count = 0;
  int total_checks = 0;
  int cnt = 0;
  int t0 = 0;
  int acq_len [8] = '{0, 2, 4, 6, 8, 12, 16, 20};
  always #10 pclk = ~pclk;
  // Off the pclk grid so the RC edges never race the sampling edge
  initial begin
    #5;
    forever #50 rc_osc = ~rc_osc;
  end
  sar_adc_sequencer u_sar_adc_sequencer (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .comp_in, .rc_osc, .afe_ctl, .pin_in, .pin_out,
    .pin_oe_n, .conv_irq
  );
  sar_afe_model u_sar_afe_model (.pclk, .afe_ctl, .levels, .comp_in);
  // Edge stamp of the last go write, for timing from the request
  always @(posedge pclk) begin
    cnt <= cnt + 1;
    if (psel && penable && pwrite && paddr == 8'h00 && pwdata[1]) begin
      t0 <= cnt;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string what, input logic [31:0] seen,
                     input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // No wait-state count is assumed; the watchdog ends a hang
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  function automatic logic part_ok(input logic [9:0] r, input logic [9:0] l);
    logic [9:0] m;
    part_ok = 1'b0;
    for (int k = 1; k < 10; k++) begin
      m = 10'h3FF << k;
      if (((r ^ l) & m) == 0 && (r & ~m) == (r[k] ? ~m : 10'h000)) begin
        part_ok = 1'b1;
      end
    end
  endfunction : part_ok
  task automatic conv(input logic [3:0] ch, input logic [2:0] cs,
                      input logic [2:0] acq, input logic ab);
    int d, el, t1;
    logic [31:0] res;
    d = 2 << (int'(cs[1:0]) * 2 + int'(cs[2]));
    apb(1'b1, sar_adc_pkg::OFF_CTRL2, {26'h0, acq, cs});
    apb(1'b1, sar_adc_pkg::OFF_CTRL0, {26'h0, ch, 2'b01});
    repeat (10) @(posedge pclk);
    apb(1'b1, sar_adc_pkg::OFF_CTRL0, {26'h0, ch, 2'b11});
    if (acq != 3'h0) begin
      apb(1'b0, sar_adc_pkg::OFF_CTRL0, 32'h0);
      chk("go during acquisition", rd[1], 1'b1);
    end
    if (ab) begin
      repeat (300) @(posedge pclk);
      apb(1'b1, sar_adc_pkg::OFF_CTRL0, {26'h0, ch, 2'b01});
    end
    while (afe_ctl.discharge !== 1'b1) begin
      @(posedge pclk);
    end
    el = cnt - t0;
    t1 = cnt;
    while (afe_ctl.discharge !== 1'b0) begin
      @(posedge pclk);
    end
    if (cs[1:0] != 2'h3) begin
      // An abort restarts the divider, so its hold-off ends one edge later
      chk("hold time", cnt - t1, 2 * d + int'(ab));
      if (!ab) begin
        chk("conv time", el >= (acq_len[acq] + 11) * d
            && el <= (acq_len[acq] + 12) * d + 2, 1'b1);
      end
    end
    apb(1'b0, sar_adc_pkg::OFF_RESH, 32'h0);
    res = rd << 8;
    apb(1'b0, sar_adc_pkg::OFF_RESL, 32'h0);
    res = res | rd;
    if (ab) begin
      chk("partial", part_ok(res[9:0], levels[ch]) && res[31:10] == 0,
          1);
    end else if (cs != 3'h0) begin
      chk("result", res, {22'h0, levels[ch]});
    end
    apb(1'b0, sar_adc_pkg::OFF_CTRL0, 32'h0);
    chk("go cleared", rd[1], 1'b0);
    apb(1'b0, sar_adc_pkg::OFF_IRQ, 32'h0);
    chk("done flag", rd[0], !ab);
    chk("interrupt", conv_irq, irq_on && !ab);
    apb(1'b1, sar_adc_pkg::OFF_IRQ, {30'h0, irq_on, 1'b1});
    repeat (2) @(posedge pclk);
    chk("interrupt cleared", conv_irq, 1'b0);
  endtask : conv
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : end_of_test
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    for (int i = 0; i < 16; i++) begin
      levels[i] = 10'(i * 59 + 17);
    end
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    @(negedge pclk);
    chk("front end idle", 32'(afe_ctl), 32'h0);
    chk("drivers off", pin_oe_n, 12'hFFF);
    apb(1'b0, sar_adc_pkg::OFF_CTRL2, 32'h0);
    chk("ctrl2 reset", rd, 32'h0);
    apb(1'b0, sar_adc_pkg::OFF_ANSEL, 32'h0);
    chk("analog select reset", rd, 32'hFFF);
    apb(1'b0, 8'h30, 32'h0);
    chk("unmapped error", {rd[30:0], err}, 32'h1);
    $display("reset test done");
    for (int p = 0; p < 3; p++) begin
      for (int q = 0; q < 2; q++) begin
        apb(1'b1, sar_adc_pkg::OFF_CTRL1, 32'(p + 4 * q));
        @(negedge pclk);
        chk("refs", {afe_ctl.pos_ref_select, afe_ctl.neg_ref_select},
            32'(p * 2 + q));
      end
    end
    $display("reference test done");
    apb(1'b1, sar_adc_pkg::OFF_ANSEL, 32'h0F0);
    apb(1'b1, sar_adc_pkg::OFF_DIR, 32'h00F);
    apb(1'b1, sar_adc_pkg::OFF_PORT_OUT, 32'hABC);
    pin_in <= 12'hA5C;
    repeat (4) @(posedge pclk);
    apb(1'b0, sar_adc_pkg::OFF_PORT_IN, 32'h0);
    chk("port read", rd, 32'hA0C);
    chk("pins", {pin_out, pin_oe_n}, 32'hABC00F);
    $display("port test done");
    irq_on = 1'b1;
    apb(1'b1, sar_adc_pkg::OFF_IRQ, 32'h2);
    for (int c = 0; c < 8; c++) begin
      conv(4'(c), 3'(c), 3'h0, 1'b0);
    end
    $display("clock source test done");
    irq_on = 1'b0;
    apb(1'b1, sar_adc_pkg::OFF_IRQ, 32'h0);
    apb(1'b1, sar_adc_pkg::OFF_ANSEL, 32'hFFF);
    apb(1'b1, sar_adc_pkg::OFF_DIR, 32'hFFF);
    for (int a = 1; a < 8; a++) begin
      conv(4'(a + 8), 3'h1, 3'(a), 1'b0);
    end
    $display("acquisition test done");
    conv(4'h9, 3'h6, 3'h0, 1'b1);
    $display("abort test done");
    end_of_test();
  end
  initial begin
    repeat (20000) @(posedge pclk);
    bad_count++;
    end_of_test();
  end
endmodule : sar_adc_sequencer_test
bind sar_adc_sequencer sar_adc_checker u_sar_adc_checker (
  .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
  .pready, .pslverr, .comp_in, .rc_osc, .afe_ctl, .pin_in, .pin_out,
  .pin_oe_n, .conv_irq
);
`default_nettype wire
